// *** rtl/hsfc_top.sv ***
// product string array, feature configuration and their effects on the hub
`timescale 1ns/1ns
module hsfc_top #(
    parameter int STEP_CYCLES = hsfc_pkg::STEP_CYCLES,
    parameter int NPORTS = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration port, driven by the EEPROM loader or the SMBus slave
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    // one-time-programmable delay field
    input wire logic [2:0] otp_power_reenable_delay,
    // string descriptor request from the hub controller
    input wire logic desc_req,
    input wire logic [7:0] desc_index,
    output logic desc_none,
    output logic desc_valid,
    output logic [7:0] desc_data,
    output logic desc_last,
    input wire logic desc_ready,
    // indicator levels from the hub core
    input wire logic high_speed_link_in,
    input wire logic high_speed_suspend_in,
    input wire logic super_speed_link_in,
    input wire logic super_speed_suspend_in,
    // indicator pins
    output logic high_speed_link_indicator,
    output logic high_speed_link_indicator_oe,
    output logic high_speed_suspend_indicator,
    output logic high_speed_suspend_indicator_oe,
    output logic super_speed_link_indicator,
    output logic super_speed_link_indicator_oe,
    output logic super_speed_suspend_indicator,
    output logic super_speed_suspend_indicator_oe,
    // port power control
    input wire logic bc_mode_change,
    input wire logic [NPORTS-1:0] port_power_request,
    output logic [NPORTS-1:0] port_power_switch_enable,
    output logic power_reenable_wait,
    // phy control
    output logic superspeed_spread_spectrum_off
);
    initial begin
        if (NPORTS < 1) begin
            $error("at least one downstream port is needed");
        end
        if (STEP_CYCLES < 1) begin
            $error("step length must be at least one cycle");
        end
    end

    // register state
    logic [7:0] product_text_byte_r [hsfc_pkg::PROD_TEXT_BYTES];
    logic [6:0] product_text_length_r;
    logic indicator_output_enable_r;
    logic [2:0] power_reenable_delay_r;
    logic superspeed_spread_spectrum_off_r;

    // address decode
    logic hit_len;
    logic hit_text;
    logic hit_feat;
    logic [5:0] text_idx;

    assign hit_len = (cfg_addr == hsfc_pkg::PROD_LEN_OFS);
    assign hit_text = (cfg_addr >= hsfc_pkg::PROD_TEXT_FIRST) &&
                      (cfg_addr <= hsfc_pkg::PROD_TEXT_LAST);
    assign hit_feat = (cfg_addr == hsfc_pkg::FEATURE_OFS);
    assign text_idx = 6'(cfg_addr - hsfc_pkg::PROD_TEXT_FIRST);

    // product string bytes; contents are stored as given, UTF-16LE is up to the source
    genvar gi;
    generate
        for (gi = 0; gi < hsfc_pkg::PROD_TEXT_BYTES; gi++) begin : g_text
            always_ff @(posedge mclk) begin
                if (rst) begin
                    product_text_byte_r[gi] <= hsfc_pkg::PROD_TEXT_RESET;
                end else if (cfg_wr && hit_text && (text_idx == 6'(gi))) begin
                    product_text_byte_r[gi] <= cfg_wdata;
                end
            end
        end
    endgenerate

    // product length, zero means no string offered
    always_ff @(posedge mclk) begin
        if (rst) begin
            product_text_length_r <= hsfc_pkg::PROD_LEN_RESET;
        end else if (cfg_wr && hit_len) begin
            product_text_length_r <= cfg_wdata[6:0];
        end
    end

    // feature configuration; EEPROM load and SMBus writes share this port
    always_ff @(posedge mclk) begin
        if (rst) begin
            indicator_output_enable_r <= hsfc_pkg::FEATURE_RESET[hsfc_pkg::FEAT_IND_EN_BIT];
            power_reenable_delay_r <=
                hsfc_pkg::FEATURE_RESET[hsfc_pkg::FEAT_DELAY_HI:hsfc_pkg::FEAT_DELAY_LO];
            superspeed_spread_spectrum_off_r <=
                hsfc_pkg::FEATURE_RESET[hsfc_pkg::FEAT_SPREAD_OFF_BIT];
        end else if (cfg_wr && hit_feat) begin
            indicator_output_enable_r <= cfg_wdata[hsfc_pkg::FEAT_IND_EN_BIT];
            power_reenable_delay_r <=
                cfg_wdata[hsfc_pkg::FEAT_DELAY_HI:hsfc_pkg::FEAT_DELAY_LO];
            superspeed_spread_spectrum_off_r <= cfg_wdata[hsfc_pkg::FEAT_SPREAD_OFF_BIT];
        end
    end

    // read path; answer one cycle after the strobe, unmapped offsets read zero
    logic [7:0] feature_view;
    logic [7:0] rdata_nxt;

    always_comb begin
        feature_view = 8'h00;
        feature_view[hsfc_pkg::FEAT_IND_EN_BIT] = indicator_output_enable_r;
        feature_view[hsfc_pkg::FEAT_DELAY_HI:hsfc_pkg::FEAT_DELAY_LO] = power_reenable_delay_r;
        feature_view[hsfc_pkg::FEAT_SPREAD_OFF_BIT] = superspeed_spread_spectrum_off_r;
        feature_view = feature_view & hsfc_pkg::FEATURE_WRITE_MASK;
        rdata_nxt = 8'h00;
        if (hit_feat) begin
            rdata_nxt = feature_view;
        end else if (hit_len) begin
            rdata_nxt = {1'b0, product_text_length_r};
        end else if (hit_text) begin
            rdata_nxt = product_text_byte_r[text_idx];
        end
    end

    logic [7:0] cfg_rdata_r;
    logic cfg_rvalid_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_rdata_r <= 8'h00;
            cfg_rvalid_r <= 1'b0;
        end else begin
            cfg_rvalid_r <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata_r <= rdata_nxt;
            end
        end
    end

    assign cfg_rdata = cfg_rdata_r;
    assign cfg_rvalid = cfg_rvalid_r;

    // descriptor streamer
    hsfc_pkg::hsfc_stream_t state_r;
    logic [6:0] send_count_r;
    logic [5:0] send_idx_r;
    logic desc_valid_r;
    logic [7:0] desc_data_r;
    logic desc_last_r;
    logic desc_none_r;
    logic [6:0] len_clamped;
    logic serve_req;

    // lengths above the array size would only repeat stale bytes, so cap them
    assign len_clamped = (product_text_length_r > hsfc_pkg::PROD_LEN_MAX) ?
                         hsfc_pkg::PROD_LEN_MAX : product_text_length_r;
    assign serve_req = (desc_index == hsfc_pkg::PROD_STRING_INDEX) &&
                       (product_text_length_r != 7'h00);

    // requests arriving while a string is still going out are ignored
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= hsfc_pkg::HSFC_IDLE;
            send_count_r <= 7'h00;
            send_idx_r <= 6'h00;
            desc_valid_r <= 1'b0;
            desc_data_r <= 8'h00;
            desc_last_r <= 1'b0;
            desc_none_r <= 1'b0;
        end else begin
            desc_none_r <= 1'b0;
            case (state_r)
                hsfc_pkg::HSFC_IDLE: begin
                    if (desc_req && serve_req) begin
                        state_r <= hsfc_pkg::HSFC_SEND;
                        send_count_r <= len_clamped;
                        send_idx_r <= 6'h01;
                        desc_valid_r <= 1'b1;
                        desc_data_r <= product_text_byte_r[0];
                        desc_last_r <= (len_clamped == 7'h01);
                    end else if (desc_req) begin
                        desc_none_r <= 1'b1;
                    end
                end
                hsfc_pkg::HSFC_SEND: begin
                    if (desc_ready) begin
                        if (desc_last_r) begin
                            state_r <= hsfc_pkg::HSFC_IDLE;
                            desc_valid_r <= 1'b0;
                            desc_last_r <= 1'b0;
                        end else begin
                            desc_data_r <= product_text_byte_r[send_idx_r];
                            send_idx_r <= send_idx_r + 6'h01;
                            desc_last_r <= ({1'b0, send_idx_r} == send_count_r - 7'h01);
                        end
                    end
                end
                default: begin
                    state_r <= hsfc_pkg::HSFC_IDLE;
                    desc_valid_r <= 1'b0;
                    desc_last_r <= 1'b0;
                end
            endcase
        end
    end

    assign desc_valid = desc_valid_r;
    assign desc_data = desc_data_r;
    assign desc_last = desc_last_r;
    assign desc_none = desc_none_r;

    // indicator pins: levels follow the core, enables follow the feature bit
    logic [3:0] ind_val_r;
    logic ind_oe_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ind_val_r <= 4'h0;
            ind_oe_r <= 1'b0;
        end else begin
            ind_val_r <= {super_speed_suspend_in, super_speed_link_in,
                          high_speed_suspend_in, high_speed_link_in};
            ind_oe_r <= indicator_output_enable_r;
        end
    end

    assign high_speed_link_indicator = ind_val_r[0];
    assign high_speed_suspend_indicator = ind_val_r[1];
    assign super_speed_link_indicator = ind_val_r[2];
    assign super_speed_suspend_indicator = ind_val_r[3];
    assign high_speed_link_indicator_oe = ind_oe_r;
    assign high_speed_suspend_indicator_oe = ind_oe_r;
    assign super_speed_link_indicator_oe = ind_oe_r;
    assign super_speed_suspend_indicator_oe = ind_oe_r;

    // power re-enable sequencing
    hsfc_tmr_if tmr_bus ();

    logic [2:0] delay_effective;

    assign delay_effective = (otp_power_reenable_delay == 3'h0) ?
                             power_reenable_delay_r : otp_power_reenable_delay;
    assign tmr_bus.start = bc_mode_change;
    assign tmr_bus.steps = delay_effective;

    hsfc_power_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .tmr(tmr_bus)
    );

    logic hold_r;
    logic [NPORTS-1:0] pwr_en_r;
    logic hold_nxt;

    // a mode change in the cycle the wait ends starts a fresh wait
    assign hold_nxt = bc_mode_change || (hold_r && !tmr_bus.done);

    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_en_r <= '0;
        end else begin
            pwr_en_r <= hold_nxt ? '0 : port_power_request;
        end
    end

    assign port_power_switch_enable = pwr_en_r;
    assign power_reenable_wait = hold_r;

    // phy spread spectrum control
    logic spread_off_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            spread_off_r <= 1'b0;
        end else begin
            spread_off_r <= superspeed_spread_spectrum_off_r;
        end
    end

    assign superspeed_spread_spectrum_off = spread_off_r;
endmodule

// *** rtl/hsfc_pkg.sv ***
// constants and types of the product string and feature configuration block
// Function
// - index 2 requests with nonzero length are answered from product string bytes
// - product length bytes are returned from the byte array, capped at 64
// - every feature configuration bit resets to zero
// - feature bits 7 to 5 are read-only and read as zero
// - bit 4 clear tri-states the four indicators, set drives them
// - register delay field acts only when the one-time delay field is zero
// - on charging mode change, drop power enable, wait delay, then reassert
// - re-enable delay is delay field plus one times 200 ms
// - bit 0 set turns spread spectrum off, clear keeps it on
// - indicator enable and delay fields accept EEPROM and SMBus overwrites
// - product length resets to zero; at most 64 bytes are meaningful
package hsfc_pkg;
    // register offsets on the configuration port
    localparam logic [7:0] PROD_LEN_OFS = 8'h24;
    localparam logic [7:0] PROD_TEXT_FIRST = 8'h90;
    localparam logic [7:0] PROD_TEXT_LAST = 8'hcf;
    localparam logic [7:0] FEATURE_OFS = 8'hf0;
    // string descriptor index served from the product bytes
    localparam logic [7:0] PROD_STRING_INDEX = 8'h02;
    // size of the product byte array and the longest meaningful string
    localparam int PROD_TEXT_BYTES = 64;
    localparam logic [6:0] PROD_LEN_MAX = 7'h40;
    // feature configuration field positions
    localparam int FEAT_IND_EN_BIT = 4;
    localparam int FEAT_DELAY_HI = 3;
    localparam int FEAT_DELAY_LO = 1;
    localparam int FEAT_SPREAD_OFF_BIT = 0;
    localparam logic [7:0] FEATURE_WRITE_MASK = 8'h1f;
    // values after reset
    localparam logic [7:0] FEATURE_RESET = 8'h00;
    localparam logic [6:0] PROD_LEN_RESET = 7'h00;
    localparam logic [7:0] PROD_TEXT_RESET = 8'h00;
    // timing: one delay step and the clock rate
    localparam int STEP_TIME_MS = 200;
    localparam longint CLK_HZ = 64'd50_000_000;
    localparam int STEP_CYCLES = int'((CLK_HZ * STEP_TIME_MS) / 1000);
    // descriptor streamer states
    typedef enum logic [0:0] {
        HSFC_IDLE = 1'b0,
        HSFC_SEND = 1'b1
    } hsfc_stream_t;
endpackage

// *** rtl/hsfc_tmr_if.sv ***
// handshake between the configuration block and its power re-enable timer
`timescale 1ns/1ns
interface hsfc_tmr_if;
    logic start;
    logic [2:0] steps;
    logic running;
    logic done;
    modport ctl (
        output start,
        output steps,
        input running,
        input done
    );
    modport tmr (
        input start,
        input steps,
        output running,
        output done
    );
endinterface

// *** rtl/hsfc_power_timer.sv ***
// timer counting the power re-enable interval in whole delay steps
`timescale 1ns/1ns
module hsfc_power_timer #(
    parameter int STEP_CYCLES = hsfc_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control from the configuration block
    hsfc_tmr_if.tmr tmr
);
    localparam int TW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
    localparam logic [TW-1:0] TICK_END = TW'(STEP_CYCLES - 1);

    initial begin
        if (STEP_CYCLES < 1) begin
            $error("step length must be at least one cycle");
        end
    end

    logic [TW-1:0] tick_r;
    logic [3:0] steps_left_r;
    logic running_r;
    logic done_r;

    assign tmr.running = running_r;
    assign tmr.done = done_r;

    // a new start restarts the whole interval, so back to back changes stretch it
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_r <= '0;
            steps_left_r <= 4'h0;
            running_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (tmr.start) begin
                tick_r <= '0;
                steps_left_r <= {1'b0, tmr.steps} + 4'h1;
                running_r <= 1'b1;
            end else if (running_r) begin
                if (tick_r == TICK_END) begin
                    tick_r <= '0;
                    steps_left_r <= steps_left_r - 4'h1;
                    if (steps_left_r == 4'h1) begin
                        running_r <= 1'b0;
                        done_r <= 1'b1;
                    end
                end else begin
                    tick_r <= tick_r + TW'(1);
                end
            end
        end
    end
endmodule

// *** bench/hsfc_top_assertions.sv ***
// concurrent checks on the ports of the string and feature configuration block
`timescale 1ns/1ns
module hsfc_top_assertions #(
    parameter int STEP_CYCLES = 4,
    parameter int NPORTS = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration port
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    // descriptor
    input wire logic desc_req,
    input wire logic [7:0] desc_index,
    input wire logic desc_none,
    input wire logic desc_valid,
    input wire logic [7:0] desc_data,
    input wire logic desc_last,
    input wire logic desc_ready,
    // pins and power
    input wire logic high_speed_link_indicator_oe,
    input wire logic super_speed_suspend_indicator_oe,
    input wire logic superspeed_spread_spectrum_off,
    input wire logic bc_mode_change,
    input wire logic [NPORTS-1:0] port_power_switch_enable,
    input wire logic power_reenable_wait
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic feat_wr;
    int wait_cnt;
    assign feat_wr = cfg_wr && cfg_addr == 8'hf0;
    // a new mode change restarts the wait, so the count restarts with it
    always_ff @(posedge mclk) begin
        if (rst || !power_reenable_wait || bc_mode_change) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    property p_rsvd;
        cfg_rd && cfg_addr == 8'hf0 |=> cfg_rdata[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("feature reserved bits not zero");
    property p_oe;
        feat_wr ##1 !feat_wr |=> high_speed_link_indicator_oe == $past(cfg_wdata[4], 2);
    endproperty
    a_oe: assert property (p_oe) else $error("indicator enable not from bit 4");
    property p_oe_same;
        high_speed_link_indicator_oe == super_speed_suspend_indicator_oe;
    endproperty
    a_oe_same: assert property (p_oe_same) else $error("indicator enables differ");
    property p_spread;
        feat_wr ##1 !feat_wr |=> superspeed_spread_spectrum_off == $past(cfg_wdata[0], 2);
    endproperty
    a_spread: assert property (p_spread) else $error("spread control not from bit 0");
    property p_none;
        desc_req && !desc_valid && desc_index != 8'h02 |=> desc_none && !desc_valid;
    endproperty
    a_none: assert property (p_none) else $error("foreign index not refused");
    property p_answer;
        desc_req && !desc_valid && desc_index == 8'h02 |=> desc_valid ^ desc_none;
    endproperty
    a_answer: assert property (p_answer) else $error("product index not answered");
    property p_hold;
        desc_valid && !desc_ready |=> desc_valid && $stable(desc_data) && $stable(desc_last);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    property p_end;
        desc_valid && desc_ready && desc_last |=> !desc_valid;
    endproperty
    a_end: assert property (p_end) else $error("bytes sent after the last");
    property p_drop;
        bc_mode_change |=> power_reenable_wait && port_power_switch_enable == '0;
    endproperty
    a_drop: assert property (p_drop) else $error("power not removed on mode change");
    property p_off;
        power_reenable_wait |-> port_power_switch_enable == '0;
    endproperty
    a_off: assert property (p_off) else $error("power enabled during wait");
    property p_bound;
        wait_cnt <= 8 * STEP_CYCLES + 2;
    endproperty
    a_bound: assert property (p_bound) else $error("re-enable wait too long");
    c_str: cover property (desc_valid && desc_ready && desc_last);
    c_none: cover property (desc_none);
    c_pwr: cover property ($fell(power_reenable_wait));
endmodule

bind hsfc_top hsfc_top_assertions #(.STEP_CYCLES(STEP_CYCLES), .NPORTS(NPORTS)) chk (
    .mclk(mclk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .desc_req(desc_req),
    .desc_index(desc_index), .desc_none(desc_none), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_last(desc_last), .desc_ready(desc_ready),
    .high_speed_link_indicator_oe(high_speed_link_indicator_oe),
    .super_speed_suspend_indicator_oe(super_speed_suspend_indicator_oe),
    .superspeed_spread_spectrum_off(superspeed_spread_spectrum_off),
    .bc_mode_change(bc_mode_change), .port_power_switch_enable(port_power_switch_enable),
    .power_reenable_wait(power_reenable_wait)
);

// *** bench/hsfc_cfg_src.sv ***
// configuration source model: EEPROM loader or SMBus host writing single bytes
`timescale 1ns/1ns
module hsfc_cfg_src (
    // clock
    input wire logic mclk,
    // configuration port
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 1'b0;
        // released data must not keep looking valid
        cfg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        // rvalid stands only in the cycle right after the strobe edge
        #1;
        d = cfg_valid_data();
    endtask
    function automatic logic [7:0] cfg_valid_data();
        return cfg_rvalid ? cfg_rdata : 8'hxx;
    endfunction
    // product text as utf-16le: letter code then a zero high byte
    function automatic logic [7:0] text_byte(input int i);
        return i[0] ? 8'h00 : 8'h41 + 8'(i / 2);
    endfunction
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the product string and feature configuration block
`timescale 1ns/1ns
module tb_top;
    localparam int STEPS = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cfg_wr, cfg_rd, cfg_rvalid, desc_none, desc_valid, desc_last, pwr_wait, spread;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, desc_data;
    logic [7:0] desc_index = 8'h00;
    logic [2:0] otp = 3'h0;
    logic desc_req = 1'b0;
    logic desc_ready = 1'b0;
    logic bc = 1'b0;
    logic [3:0] ind_in = 4'h0;
    logic [3:0] pwr_req = 4'h0;
    logic [3:0] ind, ind_oe, pwr_en;
    int err_total = 0;
    int n_compared = 0;
    always #10 mclk = ~mclk;
    hsfc_cfg_src src (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    hsfc_top #(.STEP_CYCLES(STEPS)) uut (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .otp_power_reenable_delay(otp), .desc_req(desc_req),
        .desc_index(desc_index), .desc_none(desc_none), .desc_valid(desc_valid),
        .desc_data(desc_data), .desc_last(desc_last), .desc_ready(desc_ready),
        .high_speed_link_in(ind_in[3]), .high_speed_suspend_in(ind_in[2]),
        .super_speed_link_in(ind_in[1]), .super_speed_suspend_in(ind_in[0]),
        .high_speed_link_indicator(ind[3]), .high_speed_link_indicator_oe(ind_oe[3]),
        .high_speed_suspend_indicator(ind[2]), .high_speed_suspend_indicator_oe(ind_oe[2]),
        .super_speed_link_indicator(ind[1]), .super_speed_link_indicator_oe(ind_oe[1]),
        .super_speed_suspend_indicator(ind[0]), .super_speed_suspend_indicator_oe(ind_oe[0]),
        .bc_mode_change(bc), .port_power_request(pwr_req), .port_power_switch_enable(pwr_en),
        .power_reenable_wait(pwr_wait), .superspeed_spread_spectrum_off(spread));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic reg_is(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        src.rd(a, d);
        check(nm, d, e);
    endtask
    task automatic ask(input logic [7:0] idx);
        @(posedge mclk);
        desc_req <= 1'b1;
        desc_index <= idx;
        @(posedge mclk);
        desc_req <= 1'b0;
        desc_index <= ~idx;
        // desc_none is a one-cycle pulse, so the caller looks right after the taking edge
        #1;
    endtask
    // consumer stalls every other cycle so held bytes are exercised
    task automatic take(input int n);
        int k;
        k = 0;
        for (int t = 0; t < 400 && desc_valid; t++) begin
            if (desc_ready) begin
                check("byte", desc_data, src.text_byte(k));
                check("last", desc_last, k == n - 1);
                k++;
            end
            @(posedge mclk);
            desc_ready <= t[0];
            #1;
        end
        check("count", k, n);
    endtask
    task automatic power(input int d);
        int n;
        @(posedge mclk);
        bc <= 1'b1;
        @(posedge mclk);
        bc <= 1'b0;
        @(posedge mclk);
        #1;
        check("pwr_off", {pwr_wait, pwr_en}, 5'h10);
        n = 0;
        while (pwr_wait && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("wait_len", n >= (d + 1) * STEPS - 1 && n <= (d + 1) * STEPS + 1, 1);
        @(posedge mclk);
        #1;
        check("pwr_on", pwr_en, pwr_req);
    endtask
    initial begin
        #100_000;
        err_total++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        reg_is("feat_rst", 8'hf0, 8'h00);
        reg_is("len_rst", 8'h24, 8'h00);
        check("pins_rst", {ind_oe, spread, pwr_en}, 9'h000);
        ask(8'h02);
        check("none_len0", desc_none, 1);
        src.wr(8'hf0, 8'hff);
        reg_is("feat_ro", 8'hf0, 8'h1f);
        check("oe_on", {ind_oe, spread}, 5'h1f);
        @(posedge mclk);
        ind_in <= 4'ha;
        repeat (2) @(posedge mclk);
        #1;
        check("ind", ind, 4'ha);
        src.wr(8'hf0, 8'h04);
        repeat (2) @(posedge mclk);
        #1;
        check("oe_off", {ind_oe, spread}, 5'h00);
        for (int i = 0; i < 64; i++) begin
            src.wr(8'h90 + 8'(i), src.text_byte(i));
        end
        reg_is("text_rd", 8'h92, src.text_byte(2));
        src.wr(8'h24, 8'h05);
        ask(8'h03);
        check("none_idx", desc_none, 1);
        ask(8'h02);
        take(5);
        src.wr(8'h24, 8'hd0);
        reg_is("len_rd", 8'h24, 8'h50);
        ask(8'h02);
        take(64);
        @(posedge mclk);
        pwr_req <= 4'hb;
        power(2);
        @(posedge mclk);
        otp <= 3'h3;
        power(3);
        stop_test;
    end
endmodule
